// *** verilog/fabric_to_pcix_window_remap.sv ***
// Outbound fabric to PCI/X window decode, remap and config generation.
// Assumes an APB master on the same clock and a fabric source that
// presents one address per valid cycle with no back-pressure.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module fabric_to_pcix_window_remap
	import remap_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fab_valid,
	input  wire logic [63:0] fab_addr,
	output pcix_req_t        pcix_req
);

	logic [31:0] cfg_lo_ff;
	logic [31:0] cfg_hi_ff;
	logic [31:0] m32_base_ff;
	logic [31:0] m32_remap_ff;
	logic [31:0] m32_mask_ff;
	pf_cfg_t     pf_ff [2];
	logic [7:0]  bus_num_ff;
	logic [15:0] hit_cnt_ff;
	hit_t        last_hit_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	pcix_req_t   req_ff;
	pcix_req_t   nxt_req;
	logic [3:0]  idx;
	logic        idx_ok;
	logic        apb_acc;
	logic        apb_wr;
	logic        cfg_hit;
	logic        m32_hit;
	logic [1:0]  pf_hit;
	logic [63:0] pf_xlat [2];
	logic [63:0] m32_xlat;
	logic [19:0] m32_sel;

	// Word index of an APB address; misaligned or out of range is unmapped
	function automatic logic map_ok(input logic [7:0] a);
		map_ok = a[7:6] == 2'h0 && a[1:0] == 2'h0 && a[5:2] <= IDX_STATUS;
	endfunction

	// One-hot IDSEL line for Type 0 devices 0 to 15; none for 16 to 31
	function automatic logic [15:0] idsel(input logic [4:0] dev);
		idsel = dev[4] ? 16'h0000 : 16'h0001 << dev[3:0];
	endfunction

	assign idx     = paddr[5:2];
	assign idx_ok  = map_ok(paddr);
	assign apb_acc = psel && penable;
	assign apb_wr  = apb_acc && pready_ff && pwrite && idx_ok;

	// One wait state: pready rises on the second access cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			pready_ff <= 1'b0;
		else
			pready_ff <= apb_acc && !pready_ff;
	end

	// Read data and error captured while pready is being raised
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			prdata_ff  <= REG_RESET;
			pslverr_ff <= 1'b0;
		end
		else if (apb_acc && !pready_ff)
		begin
			pslverr_ff <= !idx_ok;
			prdata_ff  <= REG_RESET;
			if (idx_ok && !pwrite)
			begin
				case (idx)
					IDX_CFG_LO:    prdata_ff <= cfg_lo_ff;
					IDX_CFG_HI:    prdata_ff <= cfg_hi_ff;
					IDX_M32_BASE:  prdata_ff <= m32_base_ff;
					IDX_M32_REMAP: prdata_ff <= m32_remap_ff;
					IDX_M32_MASK:  prdata_ff <= m32_mask_ff;
					IDX_PF0_BASE:
						prdata_ff <= pf_ff[0].base;
					IDX_PF0_BASE + 4'h1:
						prdata_ff <= pf_ff[0].remap_hi;
					IDX_PF0_BASE + 4'h2:
						prdata_ff <= pf_ff[0].remap_lo;
					IDX_PF0_BASE + 4'h3:
						prdata_ff <= pf_ff[0].mask;
					IDX_PF0_BASE + IDX_PF_STRIDE:
						prdata_ff <= pf_ff[1].base;
					IDX_PF0_BASE + IDX_PF_STRIDE + 4'h1:
						prdata_ff <= pf_ff[1].remap_hi;
					IDX_PF0_BASE + IDX_PF_STRIDE + 4'h2:
						prdata_ff <= pf_ff[1].remap_lo;
					IDX_PF0_BASE + IDX_PF_STRIDE + 4'h3:
						prdata_ff <= pf_ff[1].mask;
					IDX_BUS_NUM:   prdata_ff <= {24'h0, bus_num_ff};
					IDX_STATUS:    prdata_ff <= {hit_cnt_ff, 13'h0,
						last_hit_ff};
					default:       prdata_ff <= REG_RESET;
				endcase
			end
		end
		else
			pslverr_ff <= 1'b0;
	end

	// Configuration, memory32 and bus number registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cfg_lo_ff    <= REG_RESET;
			cfg_hi_ff    <= REG_RESET;
			m32_base_ff  <= REG_RESET;
			m32_remap_ff <= REG_RESET;
			m32_mask_ff  <= REG_RESET;
			bus_num_ff   <= 8'h00;
		end
		else if (apb_wr)
		begin
			case (idx)
				IDX_CFG_LO:    cfg_lo_ff    <= pwdata & CFG_LO_WMASK;
				IDX_CFG_HI:    cfg_hi_ff    <= pwdata;
				IDX_M32_BASE:  m32_base_ff  <= pwdata & M32_WMASK;
				IDX_M32_REMAP: m32_remap_ff <= pwdata & REMAP_WMASK;
				IDX_M32_MASK:  m32_mask_ff  <= pwdata & REMAP_WMASK;
				IDX_BUS_NUM:   bus_num_ff   <= pwdata[7:0];
				default:       ;
			endcase
		end
	end

	// Prefetch window registers and decoders, one set per window
	for (genvar w = 0; w < 2; w++)
	begin : g_pf
		localparam logic [3:0] B = IDX_PF0_BASE + 4'(w) * IDX_PF_STRIDE;

		always_ff @(posedge mclk)
		begin
			if (rst)
				pf_ff[w] <= '0;
			else if (apb_wr)
			begin
				if (idx == B)
					pf_ff[w].base <= pwdata & FULL_WMASK;
				if (idx == B + 4'h1)
					pf_ff[w].remap_hi <= pwdata & REMAP_WMASK;
				if (idx == B + 4'h2)
					pf_ff[w].remap_lo <= pwdata & FULL_WMASK;
				if (idx == B + 4'h3)
					pf_ff[w].mask <= pwdata & FULL_WMASK;
			end
		end

		prefetch_window u_pf (
			.cfg  (pf_ff[w]),
			.addr (fab_addr),
			.hit  (pf_hit[w]),
			.xlat (pf_xlat[w])
		);
	end

	// Window decodes against the fabric address
	assign cfg_hit = cfg_lo_ff[CFG_EN_BIT]
		&& fab_addr[63:32] == cfg_hi_ff
		&& fab_addr[31:24] == cfg_lo_ff[31:CFG_BASE_LSB];
	assign m32_hit = m32_base_ff[WIN_EN_BIT]
		&& fab_addr[63:32] == 32'h0000_0000
		&& fab_addr[31:30] == m32_base_ff[31:30]
		&& (m32_base_ff[WIN_SIZE_BIT]
			|| fab_addr[29] == m32_base_ff[29]);

	// Memory32 translation of bits 31:12 per mask
	assign m32_sel  = m32_mask_ff[31:REMAP_LSB];
	assign m32_xlat = {32'h0000_0000,
		(m32_remap_ff[31:REMAP_LSB] & m32_sel)
			| (fab_addr[31:12] & ~m32_sel),
		fab_addr[11:0]};

	// Priority: config, memory32, prefetch 0, prefetch 1, pass-through
	always_comb
	begin
		nxt_req       = '0;
		nxt_req.valid = fab_valid;
		nxt_req.kind  = KIND_MEM;
		nxt_req.hit   = HIT_NONE;
		nxt_req.addr  = fab_addr;
		if (cfg_hit)
		begin
			nxt_req.hit = HIT_CFG;
			// Low two bits always replaced, fabric value is ignored
			if (fab_addr[23:16] == bus_num_ff)
			begin
				nxt_req.kind = KIND_CFG0;
				nxt_req.addr = {32'h0, idsel(fab_addr[15:11]),
					5'h00, fab_addr[10:2], 2'b00};
			end
			else
			begin
				nxt_req.kind = KIND_CFG1;
				nxt_req.addr = {40'h0, fab_addr[23:2], 2'b01};
			end
		end
		else if (m32_hit)
		begin
			nxt_req.hit  = HIT_M32;
			nxt_req.addr = m32_xlat;
		end
		else if (pf_hit[0])
		begin
			nxt_req.hit  = HIT_PF0;
			nxt_req.addr = pf_xlat[0];
		end
		else if (pf_hit[1])
		begin
			nxt_req.hit  = HIT_PF1;
			nxt_req.addr = pf_xlat[1];
		end
	end

	// Registered request, one cycle after the fabric address
	always_ff @(posedge mclk)
	begin
		if (rst)
			req_ff <= '0;
		else if (fab_valid)
			req_ff <= nxt_req;
		else
			req_ff.valid <= 1'b0;
	end

	// Status: last window used and count of translated requests
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			hit_cnt_ff  <= 16'h0000;
			last_hit_ff <= HIT_NONE;
		end
		else if (fab_valid)
		begin
			last_hit_ff <= nxt_req.hit;
			if (nxt_req.hit != HIT_NONE)
				hit_cnt_ff <= hit_cnt_ff + 16'h0001;     // Wraps
		end
	end

	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign pcix_req = req_ff;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_first_acc;
		psel && penable && !pready_ff;
	endsequence

	a_apb_wait: assert property (s_setup ##1 s_first_acc |=>
		pready_ff) else $error("pready not one cycle after access");
	a_bus_write: assert property (apb_wr && idx == IDX_BUS_NUM |=>
		bus_num_ff == $past(pwdata[7:0]))
		else $error("bus number write lost");
	a_m32_upper: assert property (req_ff.valid && req_ff.hit == HIT_M32
		|-> $past(fab_addr[63:32]) == 32'h0 && req_ff.addr[63:32] == 32'h0)
		else $error("memory32 hit with upper bits set");
	a_m32_size: assert property (fab_valid && !cfg_hit
		&& !m32_base_ff[WIN_SIZE_BIT]
		&& fab_addr[29] != m32_base_ff[29] |=> req_ff.hit != HIT_M32)
		else $error("512 MB window hit outside range");
	a_m32_offset: assert property (req_ff.valid && req_ff.hit == HIT_M32
		|-> req_ff.addr[11:0] == $past(fab_addr[11:0]))
		else $error("memory32 page offset changed");
	a_pf_upper: assert property (req_ff.valid && req_ff.hit == HIT_PF0
		|-> req_ff.addr[63:44] == $past(pf_ff[0].remap_hi[31:12]))
		else $error("prefetch upper remap not applied");
	a_pf_nibble: assert property (req_ff.valid && req_ff.hit == HIT_PF1
		|-> $past(fab_addr[63:60]) == 4'h0)
		else $error("prefetch hit with top nibble set");
	a_cfg_type0: assert property (fab_valid && cfg_hit
		&& fab_addr[23:16] == bus_num_ff |=> req_ff.kind == KIND_CFG0
		&& req_ff.addr[1:0] == 2'b00)
		else $error("local bus did not give Type 0");
	a_idsel_none: assert property (req_ff.valid
		&& req_ff.kind == KIND_CFG0 && $past(fab_addr[15])
		|-> req_ff.addr[31:16] == 16'h0000)
		else $error("IDSEL driven for device above 15");
	a_pass_thru: assert property (fab_valid && !cfg_hit && !m32_hit
		&& pf_hit == 2'b00 |=> req_ff.valid && req_ff.kind == KIND_MEM
		&& req_ff.addr == $past(fab_addr))
		else $error("miss was altered");

endmodule

// *** include/remap_pkg.sv ***
// Constants, types and register map of the fabric to PCI/X window remap.
// Assumes a 32-bit APB slave port and a single core clock domain.
// Summary of operation
// - Memory32 base compares fabric address bits 31:29
// - Size bit picks 512 MB or 1 GB
// - Memory32 window active only once enabled
// - Memory32 bits 31:12 remapped where mask set
// - Prefetch base bits 31:30 compared
// - Prefetch base compares bits 59:48 and 47:32
// - Prefetch base bits 63:60 fixed at zero
// - Prefetch size bit picks 1 GB or 2 GB
// - Prefetch window active only once enabled
// - Prefetch bits 63:44 always from upper remap
// - Prefetch bits 43:12 remapped where mask set
// - Configuration window hit makes configuration cycle
// - Address splits into bus, device, function, register
// - Local bus gives Type 0, else Type 1
// - Type 0 devices 0 to 15 select one-hot AD16 upward, 16 to 31 none
// - Memory32 hit needs upper 32 bits zero
package remap_pkg;

	// Register word indices, byte address is four times the index
	localparam logic [3:0] IDX_CFG_LO    = 4'h0;
	localparam logic [3:0] IDX_CFG_HI    = 4'h1;
	localparam logic [3:0] IDX_M32_BASE  = 4'h2;
	localparam logic [3:0] IDX_M32_REMAP = 4'h3;
	localparam logic [3:0] IDX_M32_MASK  = 4'h4;
	localparam logic [3:0] IDX_PF0_BASE  = 4'h5;
	localparam logic [3:0] IDX_PF_STRIDE = 4'h4;
	localparam logic [3:0] IDX_BUS_NUM   = 4'hd;
	localparam logic [3:0] IDX_STATUS    = 4'he;

	// Field positions
	localparam int CFG_EN_BIT    = 0;
	localparam int CFG_BASE_LSB  = 24;
	localparam int WIN_EN_BIT    = 0;
	localparam int WIN_SIZE_BIT  = 1;
	localparam int PF_BA47_LSB   = 2;
	localparam int PF_BA59_LSB   = 18;
	localparam int REMAP_LSB     = 12;

	// Writable bits and reset value
	localparam logic [31:0] CFG_LO_WMASK = 32'hff00_0001;
	localparam logic [31:0] M32_WMASK    = 32'he000_0003;
	localparam logic [31:0] REMAP_WMASK  = 32'hffff_f000;
	localparam logic [31:0] FULL_WMASK   = 32'hffff_ffff;
	localparam logic [31:0] BUS_WMASK    = 32'h0000_00ff;
	localparam logic [31:0] REG_RESET    = 32'h0000_0000;

	typedef enum logic [1:0] {
		KIND_MEM  = 2'h0,
		KIND_CFG0 = 2'h1,
		KIND_CFG1 = 2'h2
	} kind_t;

	typedef enum logic [2:0] {
		HIT_NONE = 3'h0,
		HIT_CFG  = 3'h1,
		HIT_M32  = 3'h2,
		HIT_PF0  = 3'h3,
		HIT_PF1  = 3'h4
	} hit_t;

	// One prefetchable window's register set
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] remap_hi;
		logic [31:0] remap_lo;
		logic [31:0] mask;
	} pf_cfg_t;

	// Request forwarded to the PCI/X engine
	typedef struct packed {
		logic        valid;
		kind_t       kind;
		hit_t        hit;
		logic [63:0] addr;
	} pcix_req_t;

endpackage

// *** verilog/prefetch_window.sv ***
// One 64-bit prefetchable window: decode and address translation.
// Purely combinational; the parent registers the result.
`timescale 1ns/100ps
module prefetch_window
	import remap_pkg::*;
(
	input  wire pf_cfg_t     cfg,
	input  wire logic [63:0] addr,
	output logic             hit,
	output logic [63:0]      xlat
);

	logic [31:0] sel;
	logic [31:0] rmp;

	// Mask and remap rearranged so bit 0 lines up with address bit 12
	assign sel = {cfg.mask[11:0], cfg.mask[31:REMAP_LSB]};
	assign rmp = {cfg.remap_lo[11:0], cfg.remap_lo[31:REMAP_LSB]};

	// Top nibble has no storage, so it must be zero to hit
	assign hit = cfg.base[WIN_EN_BIT]
		&& addr[63:60] == 4'h0
		&& addr[59:48] == cfg.base[PF_BA59_LSB +: 12]
		&& addr[47:32] == cfg.base[PF_BA47_LSB +: 16]
		&& addr[31] == cfg.base[31]
		&& (cfg.base[WIN_SIZE_BIT] || addr[30] == cfg.base[30]);

	// Upper bits forced, middle bits per mask, page offset kept
	assign xlat = {cfg.remap_hi[31:REMAP_LSB],
		(rmp & sel) | (addr[43:12] & ~sel),
		addr[11:0]};

endmodule

// *** dv/pcix_target_model.sv ***
// Far-side stand-in for the PCI/X targets behind the bridge.
// Assumes requests arrive as one-cycle valid pulses on the core clock.
`timescale 1ns/100ps
module pcix_target_model
	import remap_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire pcix_req_t  req,
	output logic [15:0]     n_taken_ff
);
	// Targets never stall, so every pulse is one accepted cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			n_taken_ff <= 16'h0;
		else if (req.valid)
			n_taken_ff <= n_taken_ff + 16'h1;
	end
endmodule

// *** dv/fabric_to_pcix_window_remap_tb.sv ***
// Self-checking bench for the fabric to PCI/X window remap.
// Assumes one wait state on APB and a result one cycle after fab_valid.
`timescale 1ns/100ps
module fabric_to_pcix_window_remap_tb;
	import remap_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fab_valid = 1'b0;
	logic [63:0] fab_addr = 64'h0;
	pcix_req_t   pcix_req;
	logic [15:0] n_taken;
	int          fails = 0;
	int          n_compared = 0;
	logic [15:0] n_hit = 16'h0;
	logic [15:0] n_req = 16'h0;
	hit_t        last_hit = HIT_NONE;
	logic [3:0]  b;
	logic [31:0] pfb;
	logic [3:0]  wi[4] = '{IDX_CFG_LO, IDX_M32_BASE, IDX_M32_REMAP,
		IDX_BUS_NUM};
	logic [31:0] wm[4] = '{CFG_LO_WMASK, M32_WMASK, REMAP_WMASK, BUS_WMASK};
	localparam logic [63:0] PA = 64'h0123_4567_5abc_d123;
	localparam logic [63:0] PE = 64'habcd_ef6d_98bc_d123;
	always #2 mclk = ~mclk;
	fabric_to_pcix_window_remap i_fabric_to_pcix_window_remap (
		.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fab_valid(fab_valid),
		.fab_addr(fab_addr), .pcix_req(pcix_req));
	pcix_target_model i_pcix_target_model (
		.mclk(mclk), .rst(rst), .req(pcix_req), .n_taken_ff(n_taken));
	function automatic logic [7:0] ra(input logic [3:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; pready, prdata and pslverr are taken at the
	// rising edge that samples pready high; only the watchdog ends a wait
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] q, input logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		if (!wr)
			check(prdata, q);
		check(pslverr, e);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One fabric request, result checked in the cycle after it is taken
	task automatic fab(input logic [63:0] a, input kind_t k, input hit_t h,
		input logic [63:0] x);
		@(posedge mclk);
		fab_valid <= 1'b1;
		fab_addr <= a;
		@(posedge mclk);
		fab_valid <= 1'b0;
		@(negedge mclk);
		check(pcix_req.valid, 1'b1);
		check(pcix_req.kind, k);
		check(pcix_req.hit, h);
		check(pcix_req.addr, x);
		n_req++;
		// Status keeps the code of every request, a miss included
		last_hit = h;
		if (h != HIT_NONE)
			n_hit++;
	endtask
	task automatic miss(input logic [63:0] a);
		fab(a, KIND_MEM, HIT_NONE, a);
	endtask
	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#80000;
		fails++;
		end_of_test();
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 15; i++)
			apb(1'b0, ra(4'(i)), 32'h0, REG_RESET, 1'b0);
		foreach (wi[i])
		begin
			apb(1'b1, ra(wi[i]), 32'hffff_ffff, 32'h0, 1'b0);
			apb(1'b0, ra(wi[i]), 32'h0, wm[i], 1'b0);
			apb(1'b1, ra(wi[i]), 32'h0, 32'h0, 1'b0);
		end
		apb(1'b0, 8'h3c, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 8'h09, 32'h0, 32'h0, 1'b1);
		$display("test registers done");
		apb(1'b1, ra(IDX_M32_BASE), 32'ha000_0000, 32'h0, 1'b0);
		apb(1'b1, ra(IDX_M32_REMAP), 32'h1234_5000, 32'h0, 1'b0);
		apb(1'b1, ra(IDX_M32_MASK), 32'hf0f0_f000, 32'h0, 1'b0);
		miss(64'h0000_0000_b456_7abc);
		apb(1'b1, ra(IDX_M32_BASE), 32'ha000_0001, 32'h0, 1'b0);
		fab(64'hb456_7abc, KIND_MEM, HIT_M32, 64'h1436_5abc);
		miss(64'h0000_0001_b456_7abc);
		miss(64'h0000_0000_8000_0010);
		apb(1'b1, ra(IDX_M32_BASE), 32'ha000_0003, 32'h0, 1'b0);
		fab(64'h8000_0010, KIND_MEM, HIT_M32, 64'h1030_5010);
		$display("test mem32 done");
		pfb = {2'b01, 12'h123, 16'h4567, 1'b0, 1'b1};
		for (int w = 0; w < 2; w++)
		begin
			b = IDX_PF0_BASE + 4'(w) * IDX_PF_STRIDE;
			apb(1'b1, ra(b), pfb, 32'h0, 1'b0);
			apb(1'b1, ra(b + 4'h1), 32'habcd_e000, 32'h0, 1'b0);
			apb(1'b1, ra(b + 4'h2), 32'h9876_5fed, 32'h0, 1'b0);
			apb(1'b1, ra(b + 4'h3), 32'hff00_0f0f, 32'h0, 1'b0);
			apb(1'b0, ra(b), 32'h0, pfb, 1'b0);
			fab(PA, KIND_MEM, hit_t'(HIT_PF0 + w), PE);
			miss(PA ^ 64'h1000_0000_0000_0000);
			miss(PA ^ 64'h0001_0000_0000_0000);
			miss(PA ^ 64'h0000_0001_0000_0000);
			miss(PA & ~64'h4000_0000);
			apb(1'b1, ra(b), pfb | 32'h2, 32'h0, 1'b0);
			fab(PA & ~64'h4000_0000, KIND_MEM,
				hit_t'(HIT_PF0 + w), PE);
			apb(1'b1, ra(b), 32'h0, 32'h0, 1'b0);
			miss(PA);
		end
		$display("test prefetch done");
		apb(1'b1, ra(IDX_BUS_NUM), 32'h1, 32'h0, 1'b0);
		apb(1'b1, ra(IDX_CFG_LO), 32'hf000_0000, 32'h0, 1'b0);
		miss(64'hf001_0020);
		apb(1'b1, ra(IDX_CFG_LO), 32'hf000_0001, 32'h0, 1'b0);
		fab(64'hf001_0020, KIND_CFG0, HIT_CFG, 64'h0001_0020);
		fab(64'hf001_7d23, KIND_CFG0, HIT_CFG, 64'h8000_0520);
		fab(64'hf001_8020, KIND_CFG0, HIT_CFG, 64'h0000_0020);
		fab(64'hf002_7d23, KIND_CFG1, HIT_CFG, 64'h0002_7d21);
		miss(64'h0000_0001_f001_0020);
		$display("test config done");
		apb(1'b0, ra(IDX_STATUS), 32'h0, {n_hit, 13'h0, last_hit}, 1'b0);
		apb(1'b1, ra(IDX_STATUS), 32'hffff_ffff, 32'h0, 1'b0);
		apb(1'b0, ra(IDX_STATUS), 32'h0, {n_hit, 13'h0, last_hit}, 1'b0);
		check(n_taken, n_req);
		$display("test status done");
		end_of_test();
	end
endmodule
